// ===== logic/wic_defs.svh
// register map, field positions, reset values and timing counts of the wake and interrupt block
`ifndef WIC_DEFS_SVH
`define WIC_DEFS_SVH

// ==========================================================
// register byte addresses
`define WIC_CTRL_OFS        8'h00
`define WIC_STATUS_OFS      8'h04
`define WIC_VECTOR_OFS      8'h08

// ==========================================================
// control fields
`define WIC_CTRL_HALT_BIT   0
`define WIC_CTRL_WDOG_BIT   1
`define WIC_CTRL_LEVEL_BIT  2
`define WIC_CTRL_PAEN_BIT   3
`define WIC_CTRL_RST        4'h0

// ==========================================================
// status fields
`define WIC_ST_MODE_LSB     0
`define WIC_ST_MASK_BIT     3
`define WIC_ST_LATCH_BIT    4
`define WIC_ST_EXT_BIT      5
`define WIC_ST_TMR_BIT      6
`define WIC_ST_OSC_BIT      7
`define WIC_ST_WDOG_BIT     8

// ==========================================================
// vector addresses
`define WIC_VEC_RESET       16'h1ffe
`define WIC_VEC_SWI         16'h1ffc
`define WIC_VEC_EXT         16'h1ffa
`define WIC_VEC_ICAP        16'h1ff8

// ==========================================================
// timing, in bus clock cycles
`define WIC_LATCH_CLR_CYC   4'h9
`define WIC_STAB_CYC        12'hfe0

// ==========================================================
// bus answers
`define WIC_RESP_OKAY       2'h0
`define WIC_RESP_SLVERR     2'h2
`define WIC_RESP_DECERR     2'h3

`endif

// ===== logic/wic_pkg.sv
// types shared by the wake and interrupt block
package wic_pkg;

  // ==========================================================
  // modes
  typedef enum {WIC_RUN, WIC_WAIT, WIC_HALT, WIC_STOP, WIC_RESTART} wic_mode_e;

  typedef enum {WIC_SEL_CTRL, WIC_SEL_STATUS, WIC_SEL_VECTOR, WIC_SEL_NONE} wic_sel_e;

  // ==========================================================
  // register bus
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } wic_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wic_axi_rsp_s;

  // ==========================================================
  // processor core side
  typedef struct packed {
    logic insn_boundary;
    logic stop_insn;
    logic wait_insn;
    logic swi_insn;
    logic rti_insn;
    logic mask_set;
    logic mask_clr;
  } wic_core_req_s;

  typedef struct packed {
    logic        vec_take;
    logic [15:0] vec_addr;
    logic        int_mask;
    logic        core_clk_en;
    logic        bus_clk_en;
    logic        tmr_clk_en;
    logic        osc_run;
    logic        wdog_en;
  } wic_core_rsp_s;

endpackage

// ===== logic/wic_stab_timer.sv
// free-running oscillator stabilisation timer
`timescale 1ns/10ps
`include "wic_defs.svh"

module wic_stab_timer import wic_pkg::*; (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic tick,
  output logic      tc
);

  logic [11:0] count_r;
  logic [11:0] count_nxt;

  // ==========================================================
  // counter
  always_comb begin
    count_nxt = count_r;
    if (tick) begin
      count_nxt = tc ? 12'h000 : count_r + 12'h001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= 12'h000;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign tc = tick && (count_r == `WIC_STAB_CYC - 12'h001);

endmodule

// ===== logic/wic_top.sv
// wake, low-power and interrupt control with its register slave
// What this block does
// - bus clock enable is the clock divided by two
// - stop with halt select set enters halt, oscillator keeps running
// - stop with halt select clear disables watchdog and stops oscillator
// - halt and wait stop core clock; timer clocks keep running
// - stop or wait clears the interrupt mask bit
// - halt and wait keep all other state unchanged
// - halt exits on timer, external request or reset after 1 to 4064 cycles
// - wait exits at once on timer, external request or reset
// - watchdog runs only when its option bit is set
// - reset pin or internal reset sets mask and fetches reset vector
// - software trap ignores mask; pending interrupts go first
// - mask bit blocks all hardware interrupts
// - falling request edge sets a latch; latch or low level requests
// - with level sense clear only the edge latch counts
// - enabled port A pins request like the request pin
// - edge latch clears nine bus cycles after recognition
// - with level sense set, request still low at return from service requests again
// - capture request needs flag, enable and clear mask
`timescale 1ns/10ps
`include "wic_defs.svh"

module wic_top import wic_pkg::*; (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire wic_axi_req_s  axi_req,
  output wic_axi_rsp_s       axi_rsp,
  input  wire wic_core_req_s core_req,
  output wic_core_rsp_s      core_rsp,
  input  wire logic          irq_pin_n,
  input  wire logic [7:0]    porta_pin,
  input  wire logic          reset_pin_n,
  input  wire logic          int_reset,
  input  wire logic          tmr_capture_flag,
  input  wire logic          tmr_capture_en
);

  // ==========================================================
  // decode
  function automatic wic_sel_e reg_sel(input logic [7:0] addr);
    case (addr)
      `WIC_CTRL_OFS:   reg_sel = WIC_SEL_CTRL;
      `WIC_STATUS_OFS: reg_sel = WIC_SEL_STATUS;
      `WIC_VECTOR_OFS: reg_sel = WIC_SEL_VECTOR;
      default:         reg_sel = WIC_SEL_NONE;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [9:0] pin_s1_r;
  logic [9:0] pin_s2_r;
  logic       ext_n_d_r;
  logic       ext_n;
  logic       ext_fall;
  logic       rst_pin_n_s;
  logic [7:0] pa_s;
  logic       irq_n_s;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_s1_r  <= 10'h3ff;
      pin_s2_r  <= 10'h3ff;
      ext_n_d_r <= 1'h1;
    end else begin
      pin_s1_r  <= {reset_pin_n, irq_pin_n, porta_pin};
      pin_s2_r  <= pin_s1_r;
      ext_n_d_r <= ext_n;
    end
  end

  assign rst_pin_n_s = pin_s2_r[9];
  assign irq_n_s     = pin_s2_r[8];
  assign pa_s        = pin_s2_r[7:0];

  // ==========================================================
  // control register and requests
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic       halt_sel;
  logic       wdog_opt;
  logic       level_sense;
  logic       pa_en;
  logic       edge_latch_r;
  logic       ext_req;
  logic       tmr_req;
  logic       hw_pend;
  logic       i_mask_r;
  logic       core_rst;

  assign halt_sel    = ctrl_r[`WIC_CTRL_HALT_BIT];
  assign wdog_opt    = ctrl_r[`WIC_CTRL_WDOG_BIT];
  assign level_sense = ctrl_r[`WIC_CTRL_LEVEL_BIT];
  assign pa_en       = ctrl_r[`WIC_CTRL_PAEN_BIT];

  assign ext_n    = irq_n_s & (~pa_en | (&pa_s));
  assign ext_fall = ext_n_d_r & ~ext_n;
  // a pin held low after return from service re-requests in level mode
  assign ext_req  = edge_latch_r | (level_sense & ~ext_n);
  assign tmr_req  = tmr_capture_flag & tmr_capture_en;
  assign hw_pend  = (ext_req | tmr_req) & ~i_mask_r;
  assign core_rst = ~rst_pin_n_s | int_reset;

  // ==========================================================
  // clock divider and stabilisation timer
  logic bus_en_r;
  logic stab_tc;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_en_r <= 1'h0;
    end else begin
      bus_en_r <= ~bus_en_r;
    end
  end

  // free-running, so the halt exit delay depends on where it stands
  wic_stab_timer u_stab (
    .clk   (clk),
    .reset (reset),
    .tick  (bus_en_r),
    .tc    (stab_tc)
  );

  // ==========================================================
  // mode, mask and vectoring
  wic_mode_e   mode_r;
  wic_mode_e   mode_nxt;
  logic        i_mask_nxt;
  logic        rst_pend_r;
  logic        rst_pend_nxt;
  logic        wdog_dis_r;
  logic        wdog_dis_nxt;
  logic        osc_run_r;
  logic        osc_run_nxt;
  logic        edge_latch_nxt;
  logic [3:0]  clr_cnt_r;
  logic [3:0]  clr_cnt_nxt;
  logic        vec_take_r;
  logic        vec_take_nxt;
  logic [15:0] vec_addr_r;
  logic [15:0] vec_addr_nxt;
  logic        step;
  logic        latch_clr;
  logic        wake;

  assign step      = bus_en_r && mode_r == WIC_RUN;
  assign latch_clr = bus_en_r && clr_cnt_r == 4'h1;
  assign wake      = core_rst | ((ext_req | tmr_req) & ~i_mask_r);

  always_comb begin
    mode_nxt       = mode_r;
    i_mask_nxt     = i_mask_r;
    rst_pend_nxt   = rst_pend_r;
    wdog_dis_nxt   = wdog_dis_r;
    osc_run_nxt    = osc_run_r;
    clr_cnt_nxt    = clr_cnt_r;
    vec_take_nxt   = 1'h0;
    vec_addr_nxt   = vec_addr_r;
    if (bus_en_r && clr_cnt_r != 4'h0) begin
      clr_cnt_nxt = clr_cnt_r - 4'h1;
    end
    if (core_req.mask_clr && step) begin
      i_mask_nxt = 1'h0;
    end
    if (core_req.mask_set && step) begin
      i_mask_nxt = 1'h1;
    end
    case (mode_r)
      WIC_RUN: begin
        if (step && rst_pend_r && !core_rst) begin
          rst_pend_nxt = 1'h0;
          vec_take_nxt = 1'h1;
          vec_addr_nxt = `WIC_VEC_RESET;
          i_mask_nxt   = 1'h1;
        end else if (step && !rst_pend_r && !core_rst && core_req.insn_boundary) begin
          if (core_req.stop_insn) begin
            i_mask_nxt = 1'h0;
            if (halt_sel) begin
              mode_nxt = WIC_HALT;
            end else begin
              mode_nxt     = WIC_STOP;
              wdog_dis_nxt = 1'h1;
              osc_run_nxt  = 1'h0;
            end
          end else if (core_req.wait_insn) begin
            i_mask_nxt = 1'h0;
            mode_nxt   = WIC_WAIT;
          end else if (hw_pend && ext_req) begin
            vec_take_nxt = 1'h1;
            vec_addr_nxt = `WIC_VEC_EXT;
            i_mask_nxt   = 1'h1;
            clr_cnt_nxt  = `WIC_LATCH_CLR_CYC;
          end else if (hw_pend) begin
            vec_take_nxt = 1'h1;
            vec_addr_nxt = `WIC_VEC_ICAP;
            i_mask_nxt   = 1'h1;
          end else if (core_req.swi_insn) begin
            vec_take_nxt = 1'h1;
            vec_addr_nxt = `WIC_VEC_SWI;
            i_mask_nxt   = 1'h1;
          end
        end
      end
      WIC_WAIT: begin
        if (wake) begin
          mode_nxt = WIC_RUN;
        end
      end
      WIC_HALT, WIC_STOP: begin
        if (wake) begin
          mode_nxt    = WIC_RESTART;
          osc_run_nxt = 1'h1;
        end
      end
      WIC_RESTART: begin
        if (stab_tc) begin
          mode_nxt = WIC_RUN;
        end
      end
      default: begin
        mode_nxt = WIC_RUN;
      end
    endcase
    if (core_rst) begin
      rst_pend_nxt = 1'h1;
      i_mask_nxt   = 1'h1;
      wdog_dis_nxt = 1'h0;
    end
    // a fresh edge in the clearing cycle is kept
    edge_latch_nxt = ext_fall | (edge_latch_r & ~latch_clr);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r       <= WIC_RUN;
      i_mask_r     <= 1'h1;
      rst_pend_r   <= 1'h1;
      wdog_dis_r   <= 1'h0;
      osc_run_r    <= 1'h1;
      edge_latch_r <= 1'h0;
      clr_cnt_r    <= 4'h0;
      vec_take_r   <= 1'h0;
      vec_addr_r   <= 16'h0000;
    end else begin
      mode_r       <= mode_nxt;
      i_mask_r     <= i_mask_nxt;
      rst_pend_r   <= rst_pend_nxt;
      wdog_dis_r   <= wdog_dis_nxt;
      osc_run_r    <= osc_run_nxt;
      edge_latch_r <= edge_latch_nxt;
      clr_cnt_r    <= clr_cnt_nxt;
      vec_take_r   <= vec_take_nxt;
      vec_addr_r   <= vec_addr_nxt;
    end
  end

  // core clock gated in low power; other state simply holds
  always_comb begin
    core_rsp             = '0;
    core_rsp.vec_take    = vec_take_r;
    core_rsp.vec_addr    = vec_addr_r;
    core_rsp.int_mask    = i_mask_r;
    core_rsp.core_clk_en = step;
    core_rsp.bus_clk_en  = bus_en_r;
    core_rsp.tmr_clk_en  = bus_en_r;
    core_rsp.osc_run     = osc_run_r;
    core_rsp.wdog_en     = wdog_opt & ~wdog_dis_r;
  end

  // ==========================================================
  // register slave
  logic        aw_full_r;
  logic        aw_full_nxt;
  logic [7:0]  awaddr_r;
  logic [7:0]  awaddr_nxt;
  logic        w_full_r;
  logic        w_full_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic        wstrb0_r;
  logic        wstrb0_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    status[`WIC_ST_MODE_LSB +: 3] = 3'(mode_r);
    status[`WIC_ST_MASK_BIT]      = i_mask_r;
    status[`WIC_ST_LATCH_BIT]     = edge_latch_r;
    status[`WIC_ST_EXT_BIT]       = ext_req;
    status[`WIC_ST_TMR_BIT]       = tmr_req;
    status[`WIC_ST_OSC_BIT]       = osc_run_r;
    status[`WIC_ST_WDOG_BIT]      = core_rsp.wdog_en;
  end

  always_comb begin
    aw_full_nxt = aw_full_r;
    awaddr_nxt  = awaddr_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    ctrl_nxt    = ctrl_r;
    if (axi_req.awvalid && !aw_full_r) begin
      aw_full_nxt = 1'h1;
      awaddr_nxt  = axi_req.awaddr;
    end
    if (axi_req.wvalid && !w_full_r) begin
      w_full_nxt = 1'h1;
      wdata_nxt  = axi_req.wdata;
      wstrb0_nxt = axi_req.wstrb[0];
    end
    if (bvalid_r && axi_req.bready) begin
      bvalid_nxt = 1'h0;
    end
    if (aw_full_r && w_full_r && !bvalid_r) begin
      aw_full_nxt = 1'h0;
      w_full_nxt  = 1'h0;
      bvalid_nxt  = 1'h1;
      case (reg_sel(awaddr_r))
        WIC_SEL_CTRL: begin
          bresp_nxt = `WIC_RESP_OKAY;
          if (wstrb0_r) begin
            ctrl_nxt = wdata_r[3:0];
          end
        end
        WIC_SEL_STATUS, WIC_SEL_VECTOR: bresp_nxt = `WIC_RESP_SLVERR;
        default: bresp_nxt = `WIC_RESP_DECERR;
      endcase
    end
    if (rvalid_r && axi_req.rready) begin
      rvalid_nxt = 1'h0;
    end
    if (axi_req.arvalid && !rvalid_r) begin
      rvalid_nxt = 1'h1;
      rresp_nxt  = `WIC_RESP_OKAY;
      case (reg_sel(axi_req.araddr))
        WIC_SEL_CTRL:   rdata_nxt = {28'h0000000, ctrl_r};
        WIC_SEL_STATUS: rdata_nxt = status;
        WIC_SEL_VECTOR: rdata_nxt = {16'h0000, vec_addr_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `WIC_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_full_r <= 1'h0;
      awaddr_r  <= 8'h00;
      w_full_r  <= 1'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb0_r  <= 1'h0;
      bvalid_r  <= 1'h0;
      bresp_r   <= `WIC_RESP_OKAY;
      rvalid_r  <= 1'h0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `WIC_RESP_OKAY;
      ctrl_r    <= `WIC_CTRL_RST;
    end else begin
      aw_full_r <= aw_full_nxt;
      awaddr_r  <= awaddr_nxt;
      w_full_r  <= w_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = ~aw_full_r;
    axi_rsp.wready  = ~w_full_r;
    axi_rsp.bvalid  = bvalid_r;
    axi_rsp.bresp   = bresp_r;
    axi_rsp.arready = ~rvalid_r;
    axi_rsp.rvalid  = rvalid_r;
    axi_rsp.rdata   = rdata_r;
    axi_rsp.rresp   = rresp_r;
  end

  // ==========================================================
  // checks
  logic [12:0] restart_cnt_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      restart_cnt_r <= 13'h0000;
    end else if (mode_r != WIC_RESTART) begin
      restart_cnt_r <= 13'h0000;
    end else if (bus_en_r) begin
      restart_cnt_r <= restart_cnt_r + 13'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  bus_clk_div_a: assert property (bus_en_r |=> !bus_en_r ##1 bus_en_r)
    else $error("bus clock enable is not clock divided by two");
  halt_entry_a: assert property (step && !rst_pend_r && !core_rst && core_req.insn_boundary
    && core_req.stop_insn && halt_sel |=> mode_r == WIC_HALT && osc_run_r)
    else $error("stop with halt select did not enter halt");
  stop_wdog_a: assert property (mode_r == WIC_STOP |-> !core_rsp.wdog_en && !osc_run_r)
    else $error("watchdog or oscillator running in stop");
  core_gate_a: assert property (mode_r != WIC_RUN |-> !core_rsp.core_clk_en && core_rsp.tmr_clk_en == bus_en_r)
    else $error("core clock running in low power");
  lp_mask_a: assert property ($rose(mode_r == WIC_WAIT || mode_r == WIC_HALT) |-> !i_mask_r)
    else $error("mask bit not cleared on low power entry");
  restart_bound_a: assert property (mode_r == WIC_RESTART |-> restart_cnt_r <= 13'h0fe0)
    else $error("halt exit delay longer than 4064 cycles");
  wait_exit_a: assert property (mode_r == WIC_WAIT && wake |=> mode_r == WIC_RUN)
    else $error("wait not left on wake request");
  wdog_opt_a: assert property (core_rsp.wdog_en |-> wdog_opt)
    else $error("watchdog enabled without option bit");
  reset_vec_a: assert property ($fell(rst_pend_r) |-> vec_take_r && vec_addr_r == `WIC_VEC_RESET && i_mask_r)
    else $error("reset did not fetch reset vector with mask set");
  hw_masked_a: assert property (vec_take_r && (vec_addr_r == `WIC_VEC_EXT || vec_addr_r == `WIC_VEC_ICAP)
    |-> !$past(i_mask_r))
    else $error("hardware interrupt taken while masked");
  swi_order_a: assert property (vec_take_r && vec_addr_r == `WIC_VEC_SWI |-> !$past(hw_pend))
    else $error("trap taken before pending interrupt");
  latch_clr_a: assert property (vec_take_r && vec_addr_r == `WIC_VEC_EXT |-> ##17 latch_clr)
    else $error("edge latch not cleared nine bus cycles after recognition");
  icap_cause_a: assert property (vec_take_r && vec_addr_r == `WIC_VEC_ICAP |-> $past(tmr_req))
    else $error("capture vector without flag and enable");

  halt_seen_c: cover property (mode_r == WIC_HALT ##[1:1000] mode_r == WIC_RUN);
  wait_wake_c: cover property (mode_r == WIC_WAIT ##1 mode_r == WIC_RUN);
  ext_take_c:  cover property (vec_take_r && vec_addr_r == `WIC_VEC_EXT);
  swi_take_c:  cover property (vec_take_r && vec_addr_r == `WIC_VEC_SWI);

endmodule

// ===== bench/wic_core_model.sv
// stand-in for the processor core: one boundary per enabled cycle, one queued instruction
`timescale 1ns/10ps

module wic_core_model import wic_pkg::*; (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          go,
  input  wire logic [2:0]    cmd,
  input  wire wic_core_rsp_s rsp,
  output wic_core_req_s      req
);
  logic [2:0] pend_r;

  // the instruction stays on offer until an enabled cycle consumes it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pend_r <= 3'h0;
    else if (go) pend_r <= cmd;
    else if (rsp.core_clk_en) pend_r <= 3'h0;
  end

  always_comb begin
    req = '0;
    req.insn_boundary = 1'b1;
    req.stop_insn = pend_r == 3'h1;
    req.wait_insn = pend_r == 3'h2;
    req.swi_insn = pend_r == 3'h3;
    req.mask_clr = pend_r == 3'h4;
    req.mask_set = pend_r == 3'h5;
  end
endmodule

// ===== bench/wake_and_interrupt_control_test.sv
// self-checking bench of the wake and interrupt block
`timescale 1ns/10ps
`include "wic_defs.svh"

module wake_and_interrupt_control_test import wic_pkg::*;;
  logic          clk, reset, irq_pin_n, reset_pin_n, int_reset, cap_f, cap_e, go, b;
  logic [7:0]    porta_pin;
  logic [2:0]    cmd;
  logic [15:0]   last_vec;
  logic [31:0]   rd;
  logic [1:0]    resp;
  wic_axi_req_s  axi_req;
  wic_axi_rsp_s  axi_rsp;
  wic_core_req_s core_req;
  wic_core_rsp_s core_rsp;
  int            num_errors = 0;
  int            cmp_count = 0;
  int            seed = 11741;
  int            takes = 0;

  wic_top dut (.clk(clk), .reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp), .core_req(core_req),
    .core_rsp(core_rsp), .irq_pin_n(irq_pin_n), .porta_pin(porta_pin), .reset_pin_n(reset_pin_n),
    .int_reset(int_reset), .tmr_capture_flag(cap_f), .tmr_capture_en(cap_e));
  wic_core_model core (.clk(clk), .reset(reset), .go(go), .cmd(cmd), .rsp(core_rsp), .req(core_req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // vector takes last one cycle; counted mid-cycle where they are settled
  always @(negedge clk) begin
    if (core_rsp.vec_take === 1'b1) begin
      takes++;
      last_vec = core_rsp.vec_addr;
    end
  end

  // ==========================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // instructions come well after any earlier take: a service routine outlasts the latch clear
  task issue(input logic [2:0] c);
    repeat (20) @(posedge clk);
    cmd <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task wait_vec(input int lim, input logic [15:0] exp);
    int t0, n;
    begin
      t0 = takes;
      n = 0;
      while (takes == t0 && n < lim) begin
        @(posedge clk);
        n++;
      end
      chk(last_vec, exp);
      chk(takes - t0, 1);
    end
  endtask

  task no_take(input int n);
    int t0;
    begin
      t0 = takes;
      repeat (n) @(posedge clk);
      chk(takes - t0, 0);
    end
  endtask

  // ready is sampled mid-cycle; the handshake then completes at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ta, tw;
    begin
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr <= a;
      axi_req.wvalid <= 1'b1;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.bready <= 1'b1;
      while (!(aw && w)) begin
        @(negedge clk);
        ta = axi_rsp.awready === 1'b1 && !aw;
        tw = axi_rsp.wready === 1'b1 && !w;
        @(posedge clk);
        if (ta) aw = 1'b1;
        if (ta) axi_req.awvalid <= 1'b0;
        if (tw) w = 1'b1;
        if (tw) axi_req.wvalid <= 1'b0;
      end
      do @(negedge clk); while (axi_rsp.bvalid !== 1'b1);
      resp = axi_rsp.bresp;
      @(posedge clk);
      axi_req.bready <= 1'b0;
    end
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(negedge clk); while (axi_rsp.arready !== 1'b1);
    @(posedge clk);
    axi_req.arvalid <= 1'b0;
    do @(negedge clk); while (axi_rsp.rvalid !== 1'b1);
    rd = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    @(posedge clk);
    axi_req.rready <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    axi_req = '0;
    {irq_pin_n, reset_pin_n, int_reset, cap_f, cap_e, go, cmd} = 9'h180;
    porta_pin = 8'hff;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wait_vec(20, `WIC_VEC_RESET);
    @(negedge clk);
    chk(core_rsp.int_mask, 1);
    b = core_rsp.bus_clk_en;
    @(negedge clk);
    chk(core_rsp.bus_clk_en, !b);
    rd_reg(8'h0c);
    chk(resp, `WIC_RESP_DECERR);
    // port A stays quiet while its enable is off, even with the mask clear
    porta_pin <= 8'hff ^ (8'h01 << ($random(seed) & 7));
    issue(3'h4);
    no_take(30);
    issue(3'h5);
    irq_pin_n <= 1'b0;
    no_take(30);
    issue(3'h4);
    wait_vec(20, `WIC_VEC_EXT);
    porta_pin <= 8'hff;
    issue(3'h4);
    no_take(40);
    wr(`WIC_CTRL_OFS, 32'h4);
    chk(resp, `WIC_RESP_OKAY);
    wait_vec(20, `WIC_VEC_EXT);
    issue(3'h4);
    wait_vec(20, `WIC_VEC_EXT);
    irq_pin_n <= 1'b1;
    wr(`WIC_CTRL_OFS, 32'h8);
    issue(3'h4);
    porta_pin <= 8'hff ^ (8'h01 << ($random(seed) & 7));
    wait_vec(20, `WIC_VEC_EXT);
    porta_pin <= 8'hff;
    issue(3'h3);
    wait_vec(20, `WIC_VEC_SWI);
    issue(3'h2);
    repeat (4) @(negedge clk);
    chk(core_rsp.int_mask, 0);
    chk(core_rsp.core_clk_en, 0);
    rd_reg(`WIC_STATUS_OFS);
    chk(rd[`WIC_ST_MODE_LSB +: 3], 3'h1);
    cap_e <= 1'b1;
    cap_f <= 1'b1;
    wait_vec(20, `WIC_VEC_ICAP);
    cap_f <= 1'b0;
    // halt select set so the watchdog survives the stop
    wr(`WIC_CTRL_OFS, 32'h3);
    issue(3'h1);
    repeat (4) @(negedge clk);
    chk(core_rsp.osc_run, 1);
    chk(core_rsp.wdog_en, 1);
    chk(core_rsp.int_mask, 0);
    b = core_rsp.tmr_clk_en;
    @(negedge clk);
    chk(core_rsp.tmr_clk_en, !b);
    rd_reg(`WIC_STATUS_OFS);
    chk(rd[`WIC_ST_MODE_LSB +: 3], 3'h2);
    cap_f <= 1'b1;
    wait_vec(9000, `WIC_VEC_ICAP);
    cap_f <= 1'b0;
    rd_reg(`WIC_VECTOR_OFS);
    chk(rd, {16'h0000, `WIC_VEC_ICAP});
    rd_reg(`WIC_CTRL_OFS);
    chk(rd, 32'h3);
    wr(`WIC_CTRL_OFS, 32'h2);
    issue(3'h1);
    repeat (4) @(negedge clk);
    chk(core_rsp.osc_run, 0);
    chk(core_rsp.wdog_en, 0);
    rd_reg(`WIC_STATUS_OFS);
    chk(rd[`WIC_ST_MODE_LSB +: 3], 3'h3);
    irq_pin_n <= 1'b0;
    wait_vec(9000, `WIC_VEC_EXT);
    irq_pin_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      if (i == 0) int_reset <= 1'b1;
      else reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      int_reset <= 1'b0;
      reset_pin_n <= 1'b1;
      wait_vec(30, `WIC_VEC_RESET);
      @(negedge clk);
      chk(core_rsp.int_mask, 1);
    end
    conclude;
  end

  initial begin
    #400000;
    num_errors++;
    $display("Error %0t: timeout", $time);
    conclude;
  end
endmodule
